// ### hdl/gpcd_consts.svh
// Purpose: constants for the two-port general purpose I/O block
// Assumes: APB byte addresses, one register per aligned word
// Notes: printed offsets are indices, byte address is four times the index
`ifndef GPCD_CONSTS_SVH
`define GPCD_CONSTS_SVH
`define GPCD_IDX_QUAD_DATA 4'h2
`define GPCD_IDX_OCTAL_DATA 4'h3
`define GPCD_IDX_QUAD_DIR 4'h6
`define GPCD_IDX_OCTAL_DIR 4'h7
`define GPCD_IDX_QUAD_PUE 4'h8
`define GPCD_IDX_OCTAL_PUE 4'h9
`define GPCD_IDX_HV_STATUS 4'ha
`define GPCD_QUAD_W 4
`define GPCD_OCTAL_W 8
`define GPCD_QUAD_IO_W 3
`define GPCD_INPUT_ONLY_BIT 3
`define GPCD_DIR_RESET 8'h00
`define GPCD_PUE_RESET 8'h00
`define GPCD_LATCH_INIT 8'h00
`define GPCD_RDATA_ZERO 32'h0000_0000
`define GPCD_HIT_LSB 6
`define GPCD_IDX_MSB 5
`define GPCD_IDX_LSB 2
`define GPCD_LANE0 0
`define GPCD_HV_STATUS_BIT 0
`define GPCD_QUAD_OUT_MASK 4'h7
`define GPCD_OCTAL_OUT_MASK 8'hff
`endif

// ### hdl/gpcd_pin_if.sv
// Purpose: bundle between port core and its pin synchroniser
// Assumes: one clock
// Notes: raw in, filtered level out
`timescale 1ns/1ps
interface gpcd_pin_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface

// ### hdl/gpcd_pkg.sv
// Purpose: shared types for the two-port I/O block
// Assumes: nothing beyond the constants header
// Notes: apb transfer state
package gpcd_pkg;
    typedef enum logic [2:0] {
        GPCD_IDLE = 3'b001,
        GPCD_SETUP = 3'b010,
        GPCD_ACCESS = 3'b100
    } gpcd_apb_state_t;
endpackage

// ### hdl/gpcd_port.sv
// Purpose: one port slice, latch, direction, pullup and pin mux
// Assumes: writes come as one-cycle strobes from the apb slave
// Notes: latch has no reset, reset leaves port data unchanged
`timescale 1ns/1ps
module gpcd_port #(
    parameter int W = 8,
    parameter logic [W-1:0] OUT_MASK = '1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // register writes
    input wire logic wr_data,
    input wire logic wr_dir,
    input wire logic wr_pue,
    input wire logic [W-1:0] wdata,
    // register views
    output logic [W-1:0] rd_data,
    output logic [W-1:0] dir,
    output logic [W-1:0] pue,
    // pad side
    input wire logic [W-1:0] level,
    output logic [W-1:0] pad_out,
    output logic [W-1:0] pad_oe,
    output logic [W-1:0] pad_pu
);
    logic [W-1:0] latch_reg, latch_next;
    logic [W-1:0] dir_reg, dir_next, pue_reg, pue_next;
    logic [W-1:0] out_reg, oe_reg, pu_reg, out_next, oe_next, pu_next;
    always_comb begin
        latch_next = wr_data ? wdata : latch_reg;
        dir_next = wr_dir ? (wdata & OUT_MASK) : dir_reg;
        pue_next = wr_pue ? wdata : pue_reg;
        out_next = latch_next & OUT_MASK;
        oe_next = dir_next & OUT_MASK;
        pu_next = pue_next & ~dir_next;
    end
    // latch deliberately unreset: port data survives reset
    always_ff @(posedge pclk) begin
        if (ce) begin
            latch_reg <= latch_next;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= '0;
            pue_reg <= '0;
            out_reg <= '0;
            oe_reg <= '0;
            pu_reg <= '0;
        end else if (ce) begin
            dir_reg <= dir_next;
            pue_reg <= pue_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end
    assign rd_data = (dir_reg & latch_reg) | (~dir_reg & level);
    assign dir = dir_reg;
    assign pue = pue_reg;
    assign pad_out = out_reg;
    assign pad_oe = oe_reg;
    assign pad_pu = pu_reg;
endmodule

// ### hdl/gpcd_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: raw pins are asynchronous to pclk
// Notes: stage one is read only by stage two
`timescale 1ns/1ps
module gpcd_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // pins
    gpcd_pin_if.sync pins
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [W-1:0] lvl_next;
    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else if (ce) begin
            s1_reg <= pins.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end
    assign pins.level = lvl_reg;
endmodule

// ### hdl/gpcd_top.sv
// Purpose: apb slave with a four-pin and an eight-pin general purpose port
// Assumes: pclk 10 MHz, presetn async active low, pins asynchronous
// Notes: unmapped addresses read zero, writes ignored, never pslverr
`timescale 1ns/1ps
`include "gpcd_consts.svh"
module gpcd_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // quad port pins
    input wire logic [`GPCD_QUAD_W-1:0] quad_pin_in,
    output logic [`GPCD_QUAD_W-1:0] quad_pin_out,
    output logic [`GPCD_QUAD_W-1:0] quad_pin_oe,
    output logic [`GPCD_QUAD_W-1:0] quad_pin_pullup,
    // high-voltage detector on the input-only pin
    input wire logic hv_detect_raw,
    output logic special_mode_allow,
    // octal port pins
    input wire logic [`GPCD_OCTAL_W-1:0] octal_pin_in,
    output logic [`GPCD_OCTAL_W-1:0] octal_pin_out,
    output logic [`GPCD_OCTAL_W-1:0] octal_pin_oe,
    output logic [`GPCD_OCTAL_W-1:0] octal_pin_pullup
);
    // ****************************************
    // apb decode
    // ****************************************
    gpcd_pkg::gpcd_apb_state_t st_reg, st_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ready_reg, ready_next;
    logic [3:0] idx;
    logic wr_ok;
    logic w_qd, w_od, w_qdir, w_odir, w_qpue, w_opue;
    logic [`GPCD_QUAD_W-1:0] q_rd, q_dir, q_pue;
    logic [`GPCD_OCTAL_W-1:0] o_rd, o_dir, o_pue;
    logic [`GPCD_QUAD_W-1:0] q_data_view;
    logic hv_level;
    logic hv_reg, hv_next;

    // index is word address; upper bits must be zero to hit
    assign idx = paddr[`GPCD_IDX_MSB:`GPCD_IDX_LSB];
    // one-cycle write strobe at the access edge where pready is high
    assign wr_ok = psel & penable & pwrite & ready_reg & pstrb[`GPCD_LANE0]
        & (paddr[31:`GPCD_HIT_LSB] == '0);
    assign w_qd = wr_ok & (idx == `GPCD_IDX_QUAD_DATA);
    assign w_od = wr_ok & (idx == `GPCD_IDX_OCTAL_DATA);
    assign w_qdir = wr_ok & (idx == `GPCD_IDX_QUAD_DIR);
    assign w_odir = wr_ok & (idx == `GPCD_IDX_OCTAL_DIR);
    assign w_qpue = wr_ok & (idx == `GPCD_IDX_QUAD_PUE);
    assign w_opue = wr_ok & (idx == `GPCD_IDX_OCTAL_PUE);

    // ****************************************
    // pin synchronisers
    // ****************************************
    gpcd_pin_if #(.W(`GPCD_QUAD_W + 1)) q_pins ();
    gpcd_pin_if #(.W(`GPCD_OCTAL_W)) o_pins ();
    assign q_pins.raw = {hv_detect_raw, quad_pin_in};
    assign o_pins.raw = octal_pin_in;

    gpcd_sync #(.W(`GPCD_QUAD_W + 1)) u_qsync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .pins(q_pins)
    );
    gpcd_sync #(.W(`GPCD_OCTAL_W)) u_osync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .pins(o_pins)
    );
    assign hv_level = q_pins.level[`GPCD_QUAD_W];

    // ****************************************
    // port slices
    // ****************************************
    // bit 3 masked off: never driven, its latch bit unreadable
    gpcd_port #(.W(`GPCD_QUAD_W), .OUT_MASK(`GPCD_QUAD_OUT_MASK)) u_quad (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .wr_data(w_qd),
        .wr_dir(w_qdir),
        .wr_pue(w_qpue),
        .wdata(pwdata[`GPCD_QUAD_W-1:0]),
        .rd_data(q_rd),
        .dir(q_dir),
        .pue(q_pue),
        .level(q_pins.level[`GPCD_QUAD_W-1:0]),
        .pad_out(quad_pin_out),
        .pad_oe(quad_pin_oe),
        .pad_pu(quad_pin_pullup)
    );
    gpcd_port #(.W(`GPCD_OCTAL_W), .OUT_MASK(`GPCD_OCTAL_OUT_MASK)) u_octal (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .wr_data(w_od),
        .wr_dir(w_odir),
        .wr_pue(w_opue),
        .wdata(pwdata[`GPCD_OCTAL_W-1:0]),
        .rd_data(o_rd),
        .dir(o_dir),
        .pue(o_pue),
        .level(o_pins.level),
        .pad_out(octal_pin_out),
        .pad_oe(octal_pin_oe),
        .pad_pu(octal_pin_pullup)
    );
    // direction bit 3 held 0, so the read mux always picks the pin level
    assign q_data_view = q_rd;

    // ****************************************
    // high-voltage detect
    // ****************************************
    // registered so the mode gate never sees a metastable level
    assign hv_next = hv_level;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_reg <= 1'b0;
        end else if (clk_en) begin
            hv_reg <= hv_next;
        end
    end

    // ****************************************
    // apb state and read data
    // ****************************************
    always_comb begin
        st_next = st_reg;
        rdata_next = rdata_reg;
        ready_next = 1'b0;
        case (st_reg)
            gpcd_pkg::GPCD_IDLE: begin
                if (psel && !penable) begin
                    st_next = gpcd_pkg::GPCD_SETUP;
                end
            end
            gpcd_pkg::GPCD_SETUP: begin
                // answer one cycle into access: pready and prdata together
                st_next = gpcd_pkg::GPCD_ACCESS;
                ready_next = 1'b1;
                rdata_next = `GPCD_RDATA_ZERO;
                if (!pwrite && paddr[31:`GPCD_HIT_LSB] == '0) begin
                    case (idx)
                        `GPCD_IDX_QUAD_DATA: rdata_next[`GPCD_QUAD_W-1:0] = q_data_view;
                        `GPCD_IDX_OCTAL_DATA: rdata_next[`GPCD_OCTAL_W-1:0] = o_rd;
                        `GPCD_IDX_QUAD_DIR: rdata_next[`GPCD_QUAD_W-1:0] = q_dir;
                        `GPCD_IDX_OCTAL_DIR: rdata_next[`GPCD_OCTAL_W-1:0] = o_dir;
                        `GPCD_IDX_QUAD_PUE: rdata_next[`GPCD_QUAD_W-1:0] = q_pue;
                        `GPCD_IDX_OCTAL_PUE: rdata_next[`GPCD_OCTAL_W-1:0] = o_pue;
                        `GPCD_IDX_HV_STATUS: rdata_next[`GPCD_HV_STATUS_BIT] = hv_reg;
                        default: rdata_next = `GPCD_RDATA_ZERO;
                    endcase
                end
            end
            gpcd_pkg::GPCD_ACCESS: begin
                if (psel && !penable) begin
                    st_next = gpcd_pkg::GPCD_SETUP;
                end else begin
                    st_next = gpcd_pkg::GPCD_IDLE;
                end
            end
            default: begin
                st_next = gpcd_pkg::GPCD_IDLE;
            end
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= gpcd_pkg::GPCD_IDLE;
            rdata_reg <= `GPCD_RDATA_ZERO;
            ready_reg <= 1'b0;
        end else if (clk_en) begin
            st_reg <= st_next;
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
        end
    end
    assign prdata = rdata_reg;
    assign pready = ready_reg;
    assign pslverr = 1'b0;
    assign special_mode_allow = hv_reg;
endmodule

// ### sim/gpcd_board.sv
// Purpose: board wiring on one port, resolves pad level
// Assumes: device driver wins over board drive
// Notes: undriven pins without pullup wander every cycle
`timescale 1ns/1ps
module gpcd_board #(
    parameter int W = 8
) (
    // device pads
    input wire logic pclk,
    input wire logic [W-1:0] pad_out,
    input wire logic [W-1:0] pad_oe,
    input wire logic [W-1:0] pad_pu,
    // board drive
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] ext_en,
    // level seen by device
    output logic [W-1:0] level
);
    logic [W-1:0] flip = '0;
    // a floating pin must never look settled
    always_ff @(posedge pclk) begin
        flip <= ~flip;
    end
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (pad_oe[i]) begin
                level[i] = pad_out[i];
            end else if (ext_en[i]) begin
                level[i] = ext[i];
            end else if (pad_pu[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = flip[i];
            end
        end
    end
endmodule

// ### sim/gpcd_top_properties.sv
// Purpose: concurrent checks on the port block answer and pins
// Assumes: clk_en held high while transfers run
// Notes: addresses are byte addresses
`timescale 1ns/1ps
module gpcd_top_properties (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins
    input wire logic [3:0] quad_pin_out,
    input wire logic [3:0] quad_pin_oe,
    input wire logic [3:0] quad_pin_pullup,
    input wire logic hv_detect_raw,
    input wire logic special_mode_allow,
    input wire logic [7:0] octal_pin_out,
    input wire logic [7:0] octal_pin_oe,
    input wire logic [7:0] octal_pin_pullup
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;
    // only lane 0 carries port bits
    assign wr_done = psel && penable && pready && pwrite && pstrb[0];
    // ****************
    // checks
    // ****************
    a_ready_wait: assert property (psel && !penable && clk_en |=> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    a_no_error: assert property (!pslverr)
        else $error("slave error raised");
    a_input_only: assert property (!quad_pin_oe[3] && !quad_pin_out[3])
        else $error("input-only pin driven");
    a_pullup_off: assert property (!(|(quad_pin_oe & quad_pin_pullup)) &&
        !(|(octal_pin_oe & octal_pin_pullup))) else $error("pullup on output pin");
    a_reset_dirs: assert property ($rose(presetn) |-> quad_pin_oe == 4'h0 &&
        octal_pin_oe == 8'h00) else $error("driver on after reset");
    a_quad_dir: assert property (wr_done && paddr == 32'h0000_0018 |=>
        quad_pin_oe == {1'b0, $past(pwdata[2:0])}) else $error("quad driver wrong");
    a_octal_dir: assert property (wr_done && paddr == 32'h0000_001c |=>
        octal_pin_oe == $past(pwdata[7:0])) else $error("octal driver wrong");
    a_octal_out: assert property (wr_done && paddr == 32'h0000_000c |=>
        octal_pin_out == $past(pwdata[7:0])) else $error("octal latch wrong");
    a_octal_pue: assert property (wr_done && paddr == 32'h0000_0024 |=>
        octal_pin_pullup == ($past(pwdata[7:0]) & ~octal_pin_oe))
        else $error("octal pullup wrong");
    a_hv_follow: assert property (($stable(hv_detect_raw) && clk_en)[*6] |->
        special_mode_allow == hv_detect_raw) else $error("detect not followed");
    a_miss_zero: assert property (pready && !pwrite && paddr[31:6] != 26'h0 |->
        prdata == 32'h0000_0000) else $error("unmapped read not zero");
endmodule
bind gpcd_top gpcd_top_properties u_props (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .quad_pin_out, .quad_pin_oe, .quad_pin_pullup,
    .hv_detect_raw, .special_mode_allow, .octal_pin_out, .octal_pin_oe, .octal_pin_pullup
);

// ### sim/gpcd_top_test.sv
// Purpose: register level test of the two-port block
// Assumes: clk_en held high except in the freeze scenario
// Notes: pins settle within six edges
`timescale 1ns/1ps
module gpcd_top_test;
    // byte address is four times the register index
    localparam logic [31:0] QDAT = 32'h0000_0008, ODAT = 32'h0000_000c;
    localparam logic [31:0] QDIR = 32'h0000_0018, ODIR = 32'h0000_001c;
    localparam logic [31:0] QPUE = 32'h0000_0020, OPUE = 32'h0000_0024;
    localparam logic [31:0] HVS = 32'h0000_0028, MISS = 32'h0000_0040;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic hv = 1'b0, pready, pslverr, special_mode_allow;
    logic clk_en = 1'b1;
    logic [31:0] paddr = '0, pwdata = '0, prdata, q;
    logic [3:0] pstrb = 4'h0, quad_lvl, quad_pin_out, quad_pin_oe, quad_pin_pullup;
    logic [3:0] quad_en = 4'hf;
    logic [7:0] octal_lvl, octal_pin_out, octal_pin_oe, octal_pin_pullup;
    logic [7:0] octal_en = 8'hff;
    int bad_count = 0, num_checks = 0;
    gpcd_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .quad_pin_in(quad_lvl), .quad_pin_out(quad_pin_out), .quad_pin_oe(quad_pin_oe),
        .quad_pin_pullup(quad_pin_pullup), .hv_detect_raw(hv),
        .special_mode_allow(special_mode_allow), .octal_pin_in(octal_lvl),
        .octal_pin_out(octal_pin_out), .octal_pin_oe(octal_pin_oe),
        .octal_pin_pullup(octal_pin_pullup));
    gpcd_board #(.W(4)) u_quad (.pclk(pclk), .pad_out(quad_pin_out), .pad_oe(quad_pin_oe),
        .pad_pu(quad_pin_pullup), .ext(4'ha), .ext_en(quad_en), .level(quad_lvl));
    gpcd_board #(.W(8)) u_octal (.pclk(pclk), .pad_out(octal_pin_out),
        .pad_oe(octal_pin_oe), .pad_pu(octal_pin_pullup), .ext(8'h5a),
        .ext_en(octal_en), .level(octal_lvl));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ****************
    // tasks
    // ****************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            end_sim();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000, 4'h0);
        chk(q, e);
    endtask
    // ****************
    // sequence
    // ****************
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(QDIR, 32'h0000_0000);
        rd_chk(ODIR, 32'h0000_0000);
        rd_chk(QPUE, 32'h0000_0000);
        rd_chk(OPUE, 32'h0000_0000);
        wr(ODAT, 32'h0000_00c3);
        rd_chk(ODAT, 32'h0000_005a);
        wr(ODIR, 32'h0000_000f);
        rd_chk(ODAT, 32'h0000_0053);
        chk(32'(octal_pin_out), 32'h0000_00c3);
        chk(32'(octal_pin_oe), 32'h0000_000f);
        wr(OPUE, 32'h0000_00ff);
        octal_en <= 8'h0f;
        repeat (6) @(posedge pclk);
        chk(32'(octal_pin_pullup), 32'h0000_00f0);
        rd_chk(ODAT, 32'h0000_00f3);
        wr(QDAT, 32'h0000_000d);
        wr(QDIR, 32'h0000_000f);
        rd_chk(QDIR, 32'h0000_0007);
        rd_chk(QDAT, 32'h0000_000d);
        chk(32'(quad_pin_out), 32'h0000_0005);
        chk(32'(quad_pin_oe), 32'h0000_0007);
        wr(QDIR, 32'h0000_0000);
        repeat (6) @(posedge pclk);
        rd_chk(QDAT, 32'h0000_000a);
        wr(QPUE, 32'h0000_000f);
        quad_en <= 4'h0;
        repeat (6) @(posedge pclk);
        chk(32'(quad_pin_pullup), 32'h0000_000f);
        rd_chk(QDAT, 32'h0000_000f);
        wr(QPUE, 32'h0000_0000);
        quad_en <= 4'hf;
        @(posedge pclk);
        chk(32'(quad_pin_pullup), 32'h0000_0000);
        wr(MISS, 32'h0000_00ff);
        rd_chk(MISS, 32'h0000_0000);
        xfer(1'b1, ODIR, 32'h0000_00ff, 4'h0);
        rd_chk(ODIR, 32'h0000_000f);
        hv <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(special_mode_allow), 32'h0000_0001);
        rd_chk(HVS, 32'h0000_0001);
        hv <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(32'(special_mode_allow), 32'h0000_0000);
        // enable low: detect path must stay frozen
        clk_en <= 1'b0;
        hv <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(special_mode_allow), 32'h0000_0000);
        clk_en <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(32'(special_mode_allow), 32'h0000_0001);
        hv <= 1'b0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(ODIR, 32'h0000_0000);
        wr(ODIR, 32'h0000_00ff);
        rd_chk(ODAT, 32'h0000_00c3);
        wr(QDIR, 32'h0000_0007);
        rd_chk(QDAT, 32'h0000_000d);
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_sim();
    end
endmodule
